// ---- hw/crc16_serial.sv ----
// Bit-serial CRC-16 register for the received request stream
`timescale 1ns/1ps
`default_nettype none
`include "tag_quiet_defines.svh"

module crc16_serial
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  output logic [15:0] crc_o
);

  // ==========================================================
  // Register and next value
  logic [15:0] crc_q; // Running remainder
  logic [15:0] crc_d; // Next remainder

  // Clear wins over a new bit, then one shift per bit
  always_comb
  begin
    crc_d = crc_q;
    if (clear_i)
    begin
      crc_d = `TQ_CRC_INIT;
    end
    else if (bit_valid_i)
    begin
      crc_d = {1'b0, crc_q[15:1]};
      if (crc_q[0] ^ bit_i)
      begin
        crc_d = crc_d ^ `TQ_CRC_POLY;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crc_q <= `TQ_CRC_INIT;
    end
    else
    begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;

endmodule
`default_nettype wire

// ---- hw/tag_quiet_defines.svh ----
// Constants for the tag quiet and ready-state command handling
`ifndef TAG_QUIET_DEFINES_SVH
`define TAG_QUIET_DEFINES_SVH

// ==========================================================
// Request flag bit positions (bit 0 is the first bit sent)
`define TQ_FLAG_INVENTORY 2
`define TQ_FLAG_ADDRESSED 5

// ==========================================================
// Command codes
`define TQ_CMD_INVENTORY 8'h01
`define TQ_CMD_STAY_QUIET 8'h02
`define TQ_CMD_RETURN_READY 8'h26
`define TQ_CMD_QUIET_STORAGE 8'hAA

// ==========================================================
// Request lengths in bits, SOF and EOF excluded
`define TQ_LEN_PLAIN 7'h20
`define TQ_LEN_ADDRESSED 7'h60
`define TQ_LEN_STORAGE 7'h68
`define TQ_RX_MAX 104
`define TQ_RX_OVERFLOW 7'h69

// ==========================================================
// Field positions inside a request aligned to bit 0
`define TQ_POS_FLAGS 0
`define TQ_POS_CMD 8
`define TQ_POS_UID_ADDR 16
`define TQ_POS_MFR 16
`define TQ_POS_UID_STORE 24

// ==========================================================
// CRC-16 of the link, bit serial and reflected
`define TQ_CRC_INIT 16'hFFFF
`define TQ_CRC_POLY 16'h8408
`define TQ_CRC_RESIDUE 16'hF0B8

// ==========================================================
// Response frame
`define TQ_RESP_FLAGS 8'h00
`define TQ_RESP_BITS 5'h18

// ==========================================================
// Retention of the quiet storage state without field
`define TQ_CLK_MHZ 200
`define TQ_RETAIN_US 1000
`define TQ_RETAIN_CYCLES (`TQ_RETAIN_US * `TQ_CLK_MHZ)

`endif

// ---- hw/tag_quiet_pkg.sv ----
// Types for the tag quiet and ready-state command handling
package tag_quiet_pkg;

  // ==========================================================
  // Tag addressing state
  typedef enum logic [1:0] {
    ST_READY,
    ST_QUIET,
    ST_QUIET_STORAGE
  } tag_state_t;

endpackage

// ---- hw/tag_quiet_state_commands.sv ----
// Tag command interpreter: stay quiet, return to ready, quiet storage
// Notes on behaviour
// RQ1: Stay quiet only addressed, full identifier carried
// RQ2: Return-to-ready request moves tag to ready
// RQ3: Reader sends flags, command, optional identifier, CRC
// RQ4: Return-to-ready answered with flags and CRC
// RQ5: Quiet storage entered silently on its command
// RQ6: Quiet storage ignores inventory-flagged requests
// RQ7: Quiet storage still serves addressed requests
// RQ8: Return-to-ready leaves quiet storage, identifier optional
// RQ9: Addressed stay quiet moves quiet storage to quiet
// RQ10: Quiet storage survives short field loss only
// RQ11: Reader sends storage request with maker code
// RQ12: Quiet storage command only in addressed form
// RQ13: Stay quiet enters quiet silently, blocks inventory
// RQ14: Bad or unknown requests get no reply
// RQ15: Addressed request needs own identifier and CRC
// RQ16: Power-up without retained storage starts ready
`timescale 1ns/1ps
`default_nettype none
`include "tag_quiet_defines.svh"

module tag_quiet_state_commands
#(
  parameter int unsigned RETAIN_CYCLES = `TQ_RETAIN_CYCLES,
  parameter logic [7:0] MFR_CODE = 8'h5A // Maker code, value arbitrary
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [63:0] unique_tag_identifier_i,
  input wire logic field_on_i,
  input wire logic link_clk_i,
  input wire logic link_frame_i,
  input wire logic link_data_i,
  output var tag_quiet_pkg::tag_state_t state_o,
  output logic inventory_req_o,
  output logic tx_frame_o,
  output logic tx_data_o
);

  // ==========================================================
  // Parameter checks
  localparam int unsigned RW = $clog2(RETAIN_CYCLES + 1);
  if (RETAIN_CYCLES < 1)
  begin : g_bad_retain
    $error("RETAIN_CYCLES must be at least one");
  end

  // CRC of the response flags byte, run from the initial value
  function automatic logic [15:0] crc_of_byte(input logic [7:0] b);
    logic [15:0] c;
    c = `TQ_CRC_INIT;
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ b[i]) ? ({1'b0, c[15:1]} ^ `TQ_CRC_POLY) : {1'b0, c[15:1]};
    return c;
  endfunction

  // ==========================================================
  // Input synchronisers: field, link clock, frame, data
  logic [3:0] meta_q; // First stage, read by second stage only
  logic [3:0] sync_q; // Second stage
  logic [3:0] prev_q; // Previous synchronised value, for edges

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      prev_q <= 4'h0;
    end
    else
    begin
      meta_q <= {field_on_i, link_clk_i, link_frame_i, link_data_i};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic field_s, frame_s, data_s; // Synchronised field, frame and data
  logic lclk_rise, lclk_fall; // Link clock edges
  logic frame_rise, frame_fall; // Frame start and end
  logic bit_take; // Take one request bit

  assign field_s = sync_q[3];
  assign frame_s = sync_q[1];
  assign data_s = sync_q[0];
  assign lclk_rise = sync_q[2] & ~prev_q[2];
  assign lclk_fall = ~sync_q[2] & prev_q[2];
  assign frame_rise = sync_q[1] & ~prev_q[1];
  assign frame_fall = ~sync_q[1] & prev_q[1];
  assign bit_take = field_s & frame_s & lclk_rise;

  // ==========================================================
  // Receive CRC
  logic [15:0] rx_crc; // Remainder over data and received CRC

  crc16_serial u_rx_crc
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(frame_rise),
    .bit_valid_i(bit_take),
    .bit_i(data_s),
    .crc_o(rx_crc)
  );

  // ==========================================================
  // Request decode
  logic [`TQ_RX_MAX-1:0] rx_shift_q, rx_shift_d; // Bits, newest at the top
  logic [6:0] rx_cnt_q, rx_cnt_d; // Bits taken, saturating
  logic end_q, end_d; // One cycle after frame end
  logic [`TQ_RX_MAX-1:0] aligned; // First bit moved to bit 0
  logic [6:0] shamt; // Alignment shift
  logic [7:0] req_flags, req_cmd; // Flags field and command code
  logic inv_flag, addr_flag; // Inventory and addressed flags
  logic uid_hit_addr, uid_hit_store; // Identifier match, both layouts
  logic good; // Frame ended and CRC checks
  logic rtr_plain, rtr_addr; // Return-to-ready, without and with identifier
  logic sq_req, qs_req; // Stay quiet and quiet storage for this tag

  assign shamt = 7'(`TQ_RX_MAX) - rx_cnt_q;
  assign aligned = rx_shift_q >> shamt;
  assign req_flags = aligned[`TQ_POS_FLAGS +: 8];
  assign req_cmd = aligned[`TQ_POS_CMD +: 8];
  assign inv_flag = req_flags[`TQ_FLAG_INVENTORY];
  assign addr_flag = req_flags[`TQ_FLAG_ADDRESSED];
  assign uid_hit_addr = aligned[`TQ_POS_UID_ADDR +: 64] == unique_tag_identifier_i; // [RQ15]
  assign uid_hit_store = aligned[`TQ_POS_UID_STORE +: 64] == unique_tag_identifier_i; // [RQ15]
  assign good = end_q & field_s & (rx_crc == `TQ_CRC_RESIDUE); // [RQ14] [RQ15]
  // Flags, command and CRC only; identifier absent [RQ3]
  assign rtr_plain = good & (rx_cnt_q == `TQ_LEN_PLAIN) & !addr_flag & !inv_flag
                     & (req_cmd == `TQ_CMD_RETURN_READY);
  assign rtr_addr = good & (rx_cnt_q == `TQ_LEN_ADDRESSED) & addr_flag & !inv_flag
                    & (req_cmd == `TQ_CMD_RETURN_READY) & uid_hit_addr; // [RQ3]
  assign sq_req = good & (rx_cnt_q == `TQ_LEN_ADDRESSED) & addr_flag & !inv_flag
                  & (req_cmd == `TQ_CMD_STAY_QUIET) & uid_hit_addr; // [RQ1]
  assign qs_req = good & (rx_cnt_q == `TQ_LEN_STORAGE) & addr_flag & !inv_flag
                  & (req_cmd == `TQ_CMD_QUIET_STORAGE) & uid_hit_store
                  & (aligned[`TQ_POS_MFR +: 8] == MFR_CODE); // [RQ11] [RQ12]

  // ==========================================================
  // Receive, state and response
  tag_quiet_pkg::tag_state_t state_q, state_d; // Addressing state
  logic [RW-1:0] retain_q, retain_d; // Cycles without field in storage
  logic inv_q, inv_d; // Inventory hand-off pulse
  logic [23:0] tx_shift_q, tx_shift_d; // Response bits, first at bit 0
  logic [4:0] tx_cnt_q, tx_cnt_d; // Response bits left
  logic tx_frame_q, tx_frame_d;
  logic tx_data_q, tx_data_d;
  logic respond; // Start a response

  // Next values for the whole block
  always_comb
  begin
    rx_shift_d = rx_shift_q;
    rx_cnt_d = rx_cnt_q;
    end_d = frame_fall & field_s;
    state_d = state_q;
    retain_d = '0;
    inv_d = 1'b0;
    tx_shift_d = tx_shift_q;
    tx_cnt_d = tx_cnt_q;
    tx_frame_d = tx_frame_q;
    tx_data_d = tx_data_q;
    respond = 1'b0;
    // Bit collection, restarted at each frame start
    if (frame_rise)
      rx_cnt_d = 7'h00;
    else if (bit_take)
    begin
      rx_shift_d = {data_s, rx_shift_q[`TQ_RX_MAX-1:1]};
      if (rx_cnt_q != `TQ_RX_OVERFLOW)
        rx_cnt_d = rx_cnt_q + 7'h01;
    end
    // Command effects by state; anything else changes nothing [RQ14]
    case (state_q)
      tag_quiet_pkg::ST_READY:
      begin
        if (rtr_plain || rtr_addr)
          respond = 1'b1; // [RQ2]
        else if (sq_req)
          state_d = tag_quiet_pkg::ST_QUIET; // [RQ13]
        else if (qs_req)
          state_d = tag_quiet_pkg::ST_QUIET_STORAGE; // [RQ5]
        else if (good && inv_flag && req_cmd == `TQ_CMD_INVENTORY)
          inv_d = 1'b1;
      end
      tag_quiet_pkg::ST_QUIET:
      begin
        // Inventory and unaddressed requests are not served [RQ13]
        if (rtr_addr)
        begin
          state_d = tag_quiet_pkg::ST_READY; // [RQ2]
          respond = 1'b1;
        end
        else if (qs_req)
          state_d = tag_quiet_pkg::ST_QUIET_STORAGE; // [RQ5]
      end
      tag_quiet_pkg::ST_QUIET_STORAGE:
      begin
        // Inventory never reaches the hand-off here [RQ6]
        if (rtr_plain || rtr_addr)
        begin
          state_d = tag_quiet_pkg::ST_READY; // [RQ8]
          respond = 1'b1;
        end
        else if (sq_req)
          state_d = tag_quiet_pkg::ST_QUIET; // [RQ9] [RQ7]
      end
      default:
        state_d = tag_quiet_pkg::ST_READY;
    endcase
    // Response bits leave on link clock falling edges [RQ4]
    if (respond)
    begin
      tx_shift_d = {~crc_of_byte(`TQ_RESP_FLAGS), `TQ_RESP_FLAGS};
      tx_cnt_d = `TQ_RESP_BITS;
    end
    else if (lclk_fall)
    begin
      if (tx_cnt_q != 5'h00)
      begin
        tx_frame_d = 1'b1;
        tx_data_d = tx_shift_q[0];
        tx_shift_d = {1'b0, tx_shift_q[23:1]};
        tx_cnt_d = tx_cnt_q - 5'h01;
      end
      else
      begin
        tx_frame_d = 1'b0;
        tx_data_d = 1'b0;
      end
    end
    // Field loss: clears quiet at once, storage only after retention
    if (!field_s)
    begin
      rx_cnt_d = 7'h00;
      tx_cnt_d = 5'h00;
      tx_frame_d = 1'b0;
      tx_data_d = 1'b0;
      inv_d = 1'b0;
      if (state_q == tag_quiet_pkg::ST_QUIET_STORAGE)
      begin
        retain_d = retain_q + RW'(1); // [RQ10]
        if (retain_q == RW'(RETAIN_CYCLES - 1))
        begin
          state_d = tag_quiet_pkg::ST_READY; // [RQ10]
          retain_d = '0;
        end
      end
      else
        state_d = tag_quiet_pkg::ST_READY;
    end
  end

  // Registers only; logic reset starts in ready
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= tag_quiet_pkg::ST_READY; // [RQ16]
      rx_shift_q <= '0;
      rx_cnt_q <= 7'h00;
      end_q <= 1'b0;
      retain_q <= '0;
      inv_q <= 1'b0;
      tx_shift_q <= 24'h000000;
      tx_cnt_q <= 5'h00;
      tx_frame_q <= 1'b0;
      tx_data_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rx_shift_q <= rx_shift_d;
      rx_cnt_q <= rx_cnt_d;
      end_q <= end_d;
      retain_q <= retain_d;
      inv_q <= inv_d;
      tx_shift_q <= tx_shift_d;
      tx_cnt_q <= tx_cnt_d;
      tx_frame_q <= tx_frame_d;
      tx_data_q <= tx_data_d;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign state_o = state_q;
  assign inventory_req_o = inv_q;
  assign tx_frame_o = tx_frame_q;
  assign tx_data_o = tx_data_q;

endmodule
`default_nettype wire

// ---- verif/reader_model.sv ----
// Reader model: shifts request frames out and clocks the reply back
`timescale 1ns/1ps
`default_nettype none
module reader_model
(
  output logic link_clk_o,
  output logic link_frame_o,
  output logic link_data_o
);
  // ==========================================================
  // One frame, bit 0 first, then tail clocks after frame end; clock idles low between pulses
  task automatic send(input logic [103:0] bits, input int len, input int tail);
    #0.5 link_frame_o = 1'b1;
    for (int i = 0; i < len; i++)
    begin
      link_data_o = bits[i];
      #24 link_clk_o = 1'b1;
      #24 link_clk_o = 1'b0;
    end
    #12 link_frame_o = 1'b0;
    // Released data line shows the inverse of the last bit
    link_data_o = ~link_data_o;
    // Keep clocking so the reply can be shifted out
    repeat (tail)
    begin
      #24 link_clk_o = 1'b1;
      #24 link_clk_o = 1'b0;
    end
  endtask
  initial
  begin
    link_clk_o = 1'b0;
    link_frame_o = 1'b0;
    link_data_o = 1'b0;
  end
endmodule
`default_nettype wire

// ---- verif/tag_quiet_assertions.sv ----
// Port checker for the tag command interpreter
`timescale 1ns/1ps
`default_nettype none
module tag_quiet_assertions
#(
  parameter int unsigned RETAIN_CYCLES = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic field_on_i,
  input wire logic link_clk_i,
  input wire logic link_frame_i,
  input wire tag_quiet_pkg::tag_state_t state_o,
  input wire logic inventory_req_o,
  input wire logic tx_frame_o,
  input wire logic tx_data_o
);
  // ==========================================================
  // Helpers: cycles without field, link falls during a reply
  int unsigned off_d, off_q;
  logic [5:0] fall_d, fall_q;
  logic lclk_q;
  always_comb
  begin
    off_d = field_on_i ? 0 : off_q + 1;
    fall_d = tx_frame_o ? fall_q + {5'h00, lclk_q & ~link_clk_i} : 6'h00;
  end
  always_ff @(posedge clk_i)
  begin
    off_q <= rst_i ? 0 : off_d;
    fall_q <= rst_i ? 6'h00 : fall_d;
    lclk_q <= link_clk_i;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_quiet_drop;
    state_o == tag_quiet_pkg::ST_QUIET && $fell(field_on_i);
  endsequence
  sequence s_field_gone;
    s_quiet_drop ##1 !field_on_i [*5];
  endsequence
  a_reset_ready: assert property ($fell(rst_i) |-> state_o == tag_quiet_pkg::ST_READY
    && !tx_frame_o && !inventory_req_o) else $error("state after reset wrong");
  a_inv_in_ready: assert property (inventory_req_o |->
    state_o == tag_quiet_pkg::ST_READY ##1 !inventory_req_o) else $error("inventory pulse bad");
  a_tx_after_frame: assert property ($rose(tx_frame_o) |->
    state_o == tag_quiet_pkg::ST_READY && !link_frame_i) else $error("reply out of place");
  a_tx_bit_count: assert property ($fell(tx_frame_o) |->
    fall_q >= 6'h17 && fall_q <= 6'h19) else $error("reply length wrong");
  a_tx_data_held: assert property ($changed(tx_data_o) |->
    tx_frame_o || $past(tx_frame_o)) else $error("reply data moved when idle");
  a_frame_no_change: assert property ((link_frame_i && field_on_i) [*8] |=>
    $stable(state_o)) else $error("state moved inside a frame");
  a_field_loss_quiet: assert property (s_field_gone |->
    state_o == tag_quiet_pkg::ST_READY) else $error("quiet kept without field");
  a_storage_kept: assert property (state_o == tag_quiet_pkg::ST_QUIET_STORAGE
    && !field_on_i && off_q + 3 < RETAIN_CYCLES |=> state_o == tag_quiet_pkg::ST_QUIET_STORAGE)
    else $error("storage lost early");
  a_retain_expire: assert property (off_q >= RETAIN_CYCLES + 6 |->
    state_o == tag_quiet_pkg::ST_READY) else $error("storage kept too long");
endmodule
bind tag_quiet_state_commands tag_quiet_assertions #(.RETAIN_CYCLES(RETAIN_CYCLES)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .field_on_i(field_on_i), .link_clk_i(link_clk_i),
  .link_frame_i(link_frame_i), .state_o(state_o), .inventory_req_o(inventory_req_o),
  .tx_frame_o(tx_frame_o), .tx_data_o(tx_data_o));
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the tag command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned RET = 16; // Shortened retention
  localparam logic [7:0] MFR = 8'h3C; // Maker code, value arbitrary
  localparam tag_quiet_pkg::tag_state_t RDY = tag_quiet_pkg::ST_READY;
  localparam tag_quiet_pkg::tag_state_t QT = tag_quiet_pkg::ST_QUIET;
  localparam tag_quiet_pkg::tag_state_t QS = tag_quiet_pkg::ST_QUIET_STORAGE;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic field_on_i = 1'b1;
  logic [63:0] unique_tag_identifier = 64'h0;
  logic link_clk, link_frame, link_data, inventory_req_o, tx_frame_o, tx_data_o;
  tag_quiet_pkg::tag_state_t state_o;
  logic [23:0] rx_q;
  logic [103:0] fr;
  int fl, n_tx = 0, n_inv = 0, n_fail = 0, total_checks = 0;
  always #2.5 clk_i = ~clk_i;
  tag_quiet_state_commands #(.RETAIN_CYCLES(RET), .MFR_CODE(MFR)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .unique_tag_identifier_i(unique_tag_identifier), .field_on_i(field_on_i),
    .link_clk_i(link_clk), .link_frame_i(link_frame), .link_data_i(link_data),
    .state_o(state_o), .inventory_req_o(inventory_req_o), .tx_frame_o(tx_frame_o),
    .tx_data_o(tx_data_o));
  reader_model rdr_u (.link_clk_o(link_clk), .link_frame_o(link_frame), .link_data_o(link_data));
  // ==========================================================
  // Monitors: count pulses and replies, collect reply bits
  always @(posedge clk_i) if (inventory_req_o === 1'b1) n_inv++;
  always @(posedge tx_frame_o) n_tx++;
  always @(posedge link_clk) if (tx_frame_o === 1'b1) rx_q = {tx_data_o, rx_q[23:1]};
  // ==========================================================
  // Link CRC, complemented for sending
  function automatic logic [15:0] crc_of(input logic [103:0] b, input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++)
      c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return ~c;
  endfunction
  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Kind: 0 short, 1 with identifier, 2 maker and identifier, 3 wrong maker
  task automatic req(input logic [7:0] flg, input logic [7:0] cmd, input int kind,
    input logic [63:0] id, input logic bad, input logic [1:0] exp, input int exp_tx);
    int tx0, inv0;
    fr = '0;
    fr[15:0] = {cmd, flg | 8'($urandom & 3)};
    fl = 16;
    if (kind >= 2) fr[23:16] = (kind == 2) ? MFR : ~MFR;
    if (kind >= 2) fl = 24;
    if (kind > 0) fr[fl +: 64] = id;
    if (kind > 0) fl += 64;
    fr[fl +: 16] = crc_of(fr, fl);
    fl += 16;
    if (bad) fr[fl - 1] = ~fr[fl - 1];
    tx0 = n_tx;
    inv0 = n_inv;
    rx_q = '1;
    rdr_u.send(fr, fl, 26);
    repeat (4) @(posedge clk_i);
    chk("state", state_o, exp);
    chk("replies", n_tx - tx0, exp_tx);
    if (exp_tx > 0) chk("reply", rx_q, {crc_of('0, 8), 8'h00});
    chk("inventory", n_inv - inv0, 24'(exp == RDY && cmd == 8'h01 && flg[2] && !bad));
  endtask
  // Field gap of n cycles, then state compare
  task automatic gap(input int n, input logic [1:0] exp);
    @(posedge clk_i) field_on_i <= 1'b0;
    repeat (n) @(posedge clk_i);
    field_on_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("state", state_o, exp);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial
  begin
    #400us;
    n_fail++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(96));
    unique_tag_identifier = {$urandom, $urandom};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("state", state_o, RDY);
    req(8'h04, 8'h01, 0, 0, 0, RDY, 0);
    req(8'h20, 8'h26, 1, unique_tag_identifier, 0, RDY, 1);
    req(8'h20, 8'h02, 1, unique_tag_identifier ^ (64'h1 << ($urandom % 64)), 0, RDY, 0);
    req(8'h00, 8'h02, 0, 0, 0, RDY, 0);
    req(8'h20, 8'h02, 1, unique_tag_identifier, 1, RDY, 0);
    req(8'h24, 8'h02, 1, unique_tag_identifier, 0, RDY, 0);
    req(8'h20, 8'h2B, 1, unique_tag_identifier, 0, RDY, 0);
    req(8'h20, 8'h02, 1, unique_tag_identifier, 0, QT, 0);
    req(8'h04, 8'h01, 0, 0, 0, QT, 0);
    req(8'h00, 8'hAA, 2, unique_tag_identifier, 0, QT, 0);
    req(8'h20, 8'hAA, 3, unique_tag_identifier, 0, QT, 0);
    req(8'h20, 8'hAA, 2, unique_tag_identifier, 0, QS, 0);
    req(8'h04, 8'h01, 0, 0, 0, QS, 0);
    for (int i = 0; i < 3; i++)
      req(8'h20, 8'h26, 1, unique_tag_identifier ^ (64'h1 << ($urandom % 64)), 0, QS, 0);
    gap(RET - 6, QS);
    req(8'h00, 8'h26, 0, 0, 0, RDY, 1);
    req(8'h20, 8'hAA, 2, unique_tag_identifier, 0, QS, 0);
    req(8'h20, 8'h02, 1, unique_tag_identifier, 0, QT, 0);
    req(8'h00, 8'h26, 0, 0, 0, QT, 0);
    req(8'h20, 8'h26, 1, unique_tag_identifier, 0, RDY, 1);
    req(8'h20, 8'h02, 1, unique_tag_identifier, 0, QT, 0);
    gap(8, RDY);
    req(8'h20, 8'hAA, 2, unique_tag_identifier, 0, QS, 0);
    gap(RET + 8, RDY);
    conclude();
  end
endmodule
`default_nettype wire
